// ---- hdl/pipe_ctrl.sv ----
// pipeline sequencing, hazard stall and prefetch control for the soft core
//
// Behaviour
// - one clock per stage, one retire per clock
// - stall on unforwardable pending result
// - slow load/store holds until access completes
// - prefetch fills during non-fetch stalls, then feeds fetch
// - barrier or synchronizing branch empties prefetch buffer
// - simultaneous hazards stall for the longest only
// - select 1 gives fetch, decode, execute
// - three stages: no data hazards, multi-cycle execute
// - select 0 gives five stages
// - five stages: execute producers stall 1-2 clocks
// - five stages: access producers stall 1 clock
// - five stages: divide and float are multi-cycle
// - select 2 gives eight stages
// - eight stages: execute producers stall 1-5 clocks
// - eight stages: first access producers stall 1-4
// - second/third access producers stall 2-3/1-2
// - fourth access load/float stalls 1 clock
// - eight stages: stream decode structural stall
// - eight stages: first access load/store ordering stall
// - eight stages: divide and long float multi-cycle
// - taken branch flushes fetch, decode, prefetch
`timescale 1ns/100ps
`default_nettype none
module pipe_ctrl #(
    parameter logic [1:0] pipeline_depth_select = pipe_ctrl_pkg::DEPTH_FIVE,
    parameter int PF_DEPTH = pipe_ctrl_pkg::PREFETCH_DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic fetch_ready_i,
    input wire logic [3:0] dec_cat_i,
    input wire logic [pipe_ctrl_pkg::REG_IDX_W-1:0] dec_src_a_i,
    input wire logic [pipe_ctrl_pkg::REG_IDX_W-1:0] dec_src_b_i,
    input wire logic [pipe_ctrl_pkg::REG_IDX_W-1:0] dec_dst_i,
    input wire logic dec_excp_i,
    input wire logic dec_long_i,
    input wire logic exec_done_i,
    input wire logic data_done_i,
    input wire logic branch_taken_i,
    output logic [pipe_ctrl_pkg::STAGE_MAX-1:0] stage_valid_o,
    output logic [$clog2(PF_DEPTH+1)-1:0] prefetch_level_o,
    output logic hold_o,
    output logic flush_o
);
    import pipe_ctrl_pkg::*;

    localparam int PFW = $clog2(PF_DEPTH + 1);
    localparam logic [PFW-1:0] PF_FULL = PFW'(PF_DEPTH);

    // whole controller state in one record, per-slot fields indexed by stage
    typedef struct packed {
        logic [STAGE_MAX-1:0] valid;                // slot holds a real instruction
        logic [STAGE_MAX-1:0][3:0] cat;             // category of each slot
        logic [STAGE_MAX-1:0][REG_IDX_W-1:0] dst;   // destination register
        logic [STAGE_MAX-1:0] excp;                 // exception option built in
        logic [STAGE_MAX-1:0] lng;                  // long float variant
        logic [PFW-1:0] pf;                         // words held in prefetch buffer
        logic hold;                                 // a stall was in force
        logic flush;                                // a taken branch flushed
    } ctrl_state_t;

    ctrl_state_t q;
    ctrl_state_t d;
    int stall_pt;       // deepest stage that must hold this cycle, 0 for none
    int last;           // commit stage index of the organisation
    int mem_idx;        // stage where data memory is accessed
    logic raw_haz;      // decode waits on a pending result
    logic strm_haz;     // stream structural conflict in decode
    logic ord_haz;      // ordering conflict in first access stage
    logic multi_busy;   // execute occupied by a multi-cycle op
    logic slow_mem;     // data access not yet complete
    logic take;         // taken branch leaving execute
    logic sync_clr;     // barrier or synchronizing branch leaving execute
    logic pf_pull;      // fetch takes a word from the buffer
    logic pf_push;      // fetched word parked in the buffer

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // commit stage index per organisation
    function automatic int last_stage(input logic [1:0] sel);
        case (sel)
            DEPTH_THREE: last_stage = LAST_THREE;
            DEPTH_EIGHT: last_stage = LAST_EIGHT;
            default: last_stage = LAST_FIVE;
        endcase
    endfunction

    // first stage at which a producer's result can be forwarded
    function automatic int ready_stage(input logic [1:0] sel, input logic [3:0] c);
        ready_stage = STG_COMPUTE;
        case (sel)
            DEPTH_FIVE: begin
                // execute producers wait; load/mul/fp wait in access
                case (c)
                    CAT_LOAD, CAT_MUL, CAT_FP: ready_stage = 4;
                    CAT_STORE, CAT_SHIFT, CAT_DIV: ready_stage = 3;
                    default: ready_stage = STG_COMPUTE;
                endcase
            end
            DEPTH_EIGHT: begin
                case (c)
                    CAT_LOAD, CAT_FP: ready_stage = 7;
                    CAT_DIV: ready_stage = 6;
                    CAT_MUL: ready_stage = 4;
                    CAT_STORE, CAT_SHIFT: ready_stage = 3;
                    default: ready_stage = STG_COMPUTE;
                endcase
            end
            // three stages forward everything from execute
            default: ready_stage = STG_COMPUTE;
        endcase
    endfunction

    // multi-cycle occupancy of the execute stage
    function automatic logic is_multi(input logic [1:0] sel, input logic [3:0] c,
                                      input logic l);
        case (sel)
            DEPTH_THREE: is_multi = (c == CAT_SHIFT) || (c == CAT_MUL) ||
                                    (c == CAT_DIV) || (c == CAT_FP);
            // divide and the long float family
            DEPTH_EIGHT: is_multi = (c == CAT_DIV) || ((c == CAT_FP) && l);
            default: is_multi = (c == CAT_DIV) || (c == CAT_FP);
        endcase
    endfunction

    // categories that may raise an exception late in the pipe
    function automatic logic excp_kind(input logic [3:0] c);
        excp_kind = (c == CAT_LOAD) || (c == CAT_STORE) || (c == CAT_DIV) || (c == CAT_FP);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // hazard detection and next-state

    // all hazards resolve to one hold point; the deepest wins, so overlap
    // never adds up
    always_comb begin
        d = q;
        last = last_stage(pipeline_depth_select);
        mem_idx = (pipeline_depth_select == DEPTH_THREE) ? STG_COMPUTE : STG_ACCESS_FIRST;
        raw_haz = 1'b0;
        strm_haz = 1'b0;
        ord_haz = 1'b0;
        // result pending where it cannot yet be forwarded
        for (int i = STG_COMPUTE; i < STAGE_MAX; i++) begin
            if (i < last && q.valid[i] && i < ready_stage(pipeline_depth_select, q.cat[i]) &&
                (q.dst[i] == dec_src_a_i || q.dst[i] == dec_src_b_i)) begin
                raw_haz = 1'b1;
            end
        end
        if (pipeline_depth_select == DEPTH_EIGHT) begin
            // stream in decode against execute and access stages
            if (dec_cat_i == CAT_STREAM && q.valid[STG_COMPUTE] &&
                q.cat[STG_COMPUTE] == CAT_STREAM) begin
                strm_haz = 1'b1;
            end
            for (int i = STG_COMPUTE; i < LAST_EIGHT; i++) begin
                if (dec_cat_i == CAT_STREAM && q.valid[i] && q.excp[i] &&
                    excp_kind(q.cat[i])) begin
                    strm_haz = 1'b1;
                end
            end
            // first access load/store behind an excepting access
            for (int i = STG_ACCESS_FIRST + 1; i < LAST_EIGHT; i++) begin
                if (q.valid[STG_ACCESS_FIRST] && q.valid[i] && q.excp[i] &&
                    excp_kind(q.cat[i]) && (q.cat[STG_ACCESS_FIRST] == CAT_LOAD ||
                    q.cat[STG_ACCESS_FIRST] == CAT_STORE)) begin
                    ord_haz = 1'b1;
                end
            end
        end
        multi_busy = q.valid[STG_COMPUTE] && !exec_done_i &&
                     is_multi(pipeline_depth_select, q.cat[STG_COMPUTE], q.lng[STG_COMPUTE]);
        slow_mem = q.valid[mem_idx] && !data_done_i &&
                   (q.cat[mem_idx] == CAT_LOAD || q.cat[mem_idx] == CAT_STORE);
        // hold point is the deepest of all active hazards
        stall_pt = 0;
        if (q.valid[STG_DECODE] && (raw_haz || strm_haz)) begin
            stall_pt = STG_DECODE;
        end
        if (multi_busy) begin
            stall_pt = STG_COMPUTE;
        end
        if (ord_haz && stall_pt < STG_ACCESS_FIRST) begin
            stall_pt = STG_ACCESS_FIRST;
        end
        // slow data access freezes up to its stage
        if (slow_mem && stall_pt < mem_idx) begin
            stall_pt = mem_idx;
        end
        take = branch_taken_i && q.valid[STG_COMPUTE] && stall_pt < STG_COMPUTE &&
               (q.cat[STG_COMPUTE] == CAT_BRANCH || q.cat[STG_COMPUTE] == CAT_SYNC_BRANCH);
        sync_clr = q.valid[STG_COMPUTE] && stall_pt < STG_COMPUTE &&
                   (q.cat[STG_COMPUTE] == CAT_BARRIER || q.cat[STG_COMPUTE] == CAT_SYNC_BRANCH);
        // stages past the hold point advance, first one gets a bubble
        for (int i = STG_DECODE; i < STAGE_MAX; i++) begin
            if (i > stall_pt) begin
                d.valid[i] = (i > last || (stall_pt != 0 && i == stall_pt + 1)) ?
                             1'b0 : q.valid[i-1];
                if (i == STG_COMPUTE) begin
                    d.cat[i] = dec_cat_i;
                    d.dst[i] = dec_dst_i;
                    d.excp[i] = dec_excp_i;
                    d.lng[i] = dec_long_i;
                end else if (i > STG_COMPUTE) begin
                    d.cat[i] = q.cat[i-1];
                    d.dst[i] = q.dst[i-1];
                    d.excp[i] = q.excp[i-1];
                    d.lng[i] = q.lng[i-1];
                end
            end
        end
        // fetch feeds from the buffer first, memory words park there
        pf_pull = 1'b0;
        pf_push = 1'b0;
        if (stall_pt == 0) begin
            pf_pull = (q.pf != '0);
            pf_push = fetch_ready_i && pf_pull;
            d.valid[STG_FETCH] = fetch_ready_i || pf_pull;
        end else if (!q.valid[STG_FETCH]) begin
            d.valid[STG_FETCH] = fetch_ready_i;
        end else begin
            pf_push = fetch_ready_i && (q.pf != PF_FULL);
        end
        d.pf = q.pf - PFW'(pf_pull) + PFW'(pf_push);
        if (sync_clr) begin
            d.pf = '0;
        end
        // taken branch drops fetch, decode and buffer; refill takes two clocks
        // the word fetched now comes from the target, so execute sees two bubbles
        if (take) begin
            d.valid[STG_FETCH] = fetch_ready_i;
            d.valid[STG_DECODE] = 1'b0;
            // the instruction behind the branch must never reach execute
            d.valid[STG_COMPUTE] = 1'b0;
            d.pf = '0;
        end
        d.hold = (stall_pt != 0);
        d.flush = take;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // reset empties every stage and the buffer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign stage_valid_o = q.valid;
    assign prefetch_level_o = q.pf;
    assign hold_o = q.hold;
    assign flush_o = q.flush;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    single_clock_a: assert property (q.valid[STG_DECODE] && stall_pt == 0 && !take |=>
        q.valid[STG_COMPUTE]) else $error("decode did not advance in one clock");
    data_bubble_a: assert property (q.valid[STG_DECODE] && raw_haz && stall_pt == 1 && !take
        |=> !q.valid[STG_COMPUTE] && q.valid[STG_DECODE]) else $error("hazard did not stall");
    slow_mem_a: assert property (slow_mem |=> q.valid[mem_idx] &&
        $stable(q.cat[mem_idx])) else $error("slow access released early");
    pf_fill_a: assert property (stall_pt != 0 && q.valid[STG_FETCH] && fetch_ready_i &&
        q.pf != PF_FULL && !take && !sync_clr |=> q.pf == $past(q.pf) + 1'b1)
        else $error("prefetch did not fill");
    pf_clear_a: assert property (sync_clr |=> q.pf == '0)
        else $error("barrier left prefetch words");
    longest_a: assert property (multi_busy && raw_haz |=> q.valid[STG_COMPUTE] &&
        q.hold) else $error("execute not held under overlap");
    no_data_haz_a: assert property (pipeline_depth_select == DEPTH_THREE &&
        q.valid[STG_DECODE] && !multi_busy && !slow_mem && !take |=> q.valid[STG_COMPUTE])
        else $error("data hazard in three stages");
    multi_hold_a: assert property (multi_busy && stall_pt == STG_COMPUTE |=>
        !q.valid[STG_COMPUTE+1]) else $error("multi-cycle op not held");
    branch_flush_a: assert property (take |=> !q.valid[STG_COMPUTE] && q.pf == '0
        ##1 !q.valid[STG_COMPUTE]) else $error("branch refill not two bubbles");

    branch_c: cover property (take ##3 q.valid[STG_COMPUTE]);
    hazard_c: cover property (raw_haz && stall_pt == 1 ##1 stall_pt == 0);
    pf_full_c: cover property (q.pf == PF_FULL ##1 stall_pt == 0);
endmodule
`default_nettype wire

// ---- hdl/pipe_ctrl_pkg.sv ----
// shared constants and types for the pipeline sequencing and hazard controller
package pipe_ctrl_pkg;
    // organisation codes carried by pipeline_depth_select
    localparam logic [1:0] DEPTH_FIVE = 2'h0;
    localparam logic [1:0] DEPTH_THREE = 2'h1;
    localparam logic [1:0] DEPTH_EIGHT = 2'h2;
    // stage slots, fetch first; the longest organisation uses all eight
    localparam int STAGE_MAX = 8;
    localparam int STG_FETCH = 0;
    localparam int STG_DECODE = 1;
    localparam int STG_COMPUTE = 2;
    localparam int STG_ACCESS_FIRST = 3;
    // index of the result commit stage per organisation
    localparam int LAST_THREE = 2;
    localparam int LAST_FIVE = 4;
    localparam int LAST_EIGHT = 7;
    // register index width of the core
    localparam int REG_IDX_W = 5;
    // default prefetch buffer depth in instruction words
    localparam int PREFETCH_DEPTH = 4;
    // instruction categories reported by the decoder
    typedef enum logic [3:0] {
        CAT_ALU = 4'h0,
        CAT_LOAD = 4'h1,
        CAT_STORE = 4'h2,
        CAT_SHIFT = 4'h3,
        CAT_MUL = 4'h4,
        CAT_DIV = 4'h5,
        CAT_FP = 4'h6,
        CAT_STREAM = 4'h7,
        CAT_BARRIER = 4'h8,
        CAT_SYNC_BRANCH = 4'h9,
        CAT_BRANCH = 4'hA
    } instr_cat_t;
endpackage

// ---- testbench/pipe_ctrl_tb.sv ----
// self-checking bench for the pipeline sequencing and hazard controller
`timescale 1ns/100ps
`default_nettype none
module pipe_ctrl_tb;
    import pipe_ctrl_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic fetch_ready_i = 1'b1; // memory answers every cycle unless a test says not
    logic [3:0] dec_cat_i = CAT_ALU;
    logic [REG_IDX_W-1:0] dec_src_a_i = 5'h02;
    logic [REG_IDX_W-1:0] dec_src_b_i = 5'h02;
    logic [REG_IDX_W-1:0] dec_dst_i = 5'h01;
    logic dec_excp_i = 1'b0;
    logic dec_long_i = 1'b0;
    logic exec_done_i = 1'b1; // multi-cycle ops finish at once by default
    logic data_done_i = 1'b1; // fast data memory by default
    logic branch_taken_i = 1'b0;
    logic [STAGE_MAX-1:0] stage_valid_o, valid_three, valid_eight;
    logic [1:0] prefetch_level_o; // clog2(2+1) bits for a two-word buffer
    logic hold_o, flush_o;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // five-stage core under test; a small buffer keeps fill checks short
    pipe_ctrl #(.pipeline_depth_select(DEPTH_FIVE), .PF_DEPTH(2)) u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .fetch_ready_i(fetch_ready_i),
        .dec_cat_i(dec_cat_i), .dec_src_a_i(dec_src_a_i), .dec_src_b_i(dec_src_b_i),
        .dec_dst_i(dec_dst_i), .dec_excp_i(dec_excp_i), .dec_long_i(dec_long_i),
        .exec_done_i(exec_done_i), .data_done_i(data_done_i),
        .branch_taken_i(branch_taken_i), .stage_valid_o(stage_valid_o),
        .prefetch_level_o(prefetch_level_o), .hold_o(hold_o), .flush_o(flush_o));
    // the other two organisations share the stimulus; only their stage valid outputs are judged
    pipe_ctrl #(.pipeline_depth_select(DEPTH_THREE)) u_dut_three (
        .clk_i(clk_i), .reset_i(reset_i), .fetch_ready_i(fetch_ready_i),
        .dec_cat_i(dec_cat_i), .dec_src_a_i(dec_src_a_i), .dec_src_b_i(dec_src_b_i),
        .dec_dst_i(dec_dst_i), .dec_excp_i(dec_excp_i), .dec_long_i(dec_long_i),
        .exec_done_i(exec_done_i), .data_done_i(data_done_i),
        .branch_taken_i(branch_taken_i), .stage_valid_o(valid_three),
        .prefetch_level_o(), .hold_o(), .flush_o());
    pipe_ctrl #(.pipeline_depth_select(DEPTH_EIGHT)) u_dut_eight (
        .clk_i(clk_i), .reset_i(reset_i), .fetch_ready_i(fetch_ready_i),
        .dec_cat_i(dec_cat_i), .dec_src_a_i(dec_src_a_i), .dec_src_b_i(dec_src_b_i),
        .dec_dst_i(dec_dst_i), .dec_excp_i(dec_excp_i), .dec_long_i(dec_long_i),
        .exec_done_i(exec_done_i), .data_done_i(data_done_i),
        .branch_taken_i(branch_taken_i), .stage_valid_o(valid_eight),
        .prefetch_level_o(), .hold_o(), .flush_o());
    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; no test needs more than a few hundred cycles
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // compare one observed value, counted either way
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // present the instruction now sitting in decode
    task automatic dec(input instr_cat_t c, input logic [4:0] d, input logic [4:0] a);
        dec_cat_i = c;
        dec_dst_i = d;
        dec_src_a_i = a;
        dec_src_b_i = a;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios; each starts and ends on a falling edge
    task automatic test_flow();
        step(8);
        chk(stage_valid_o, 8'h1F, "five stage fill");
        chk(valid_three, 8'h07, "three stage fill");
        chk(valid_eight, 8'hFF, "eight stage fill");
        chk({7'h00, hold_o}, 8'h00, "no stall");
        $display("flow done");
    endtask
    // dependent add behind a multiply, then drain the buffer with fetch idle
    task automatic test_mul_hazard();
        dec(CAT_MUL, 5'h03, 5'h04);
        step(1);
        dec(CAT_ALU, 5'h06, 5'h03);
        step(1);
        chk({7'h00, stage_valid_o[2]}, 8'h00, "bubble behind held add");
        chk({7'h00, stage_valid_o[1]}, 8'h01, "add held in decode");
        chk({7'h00, hold_o}, 8'h01, "stall reported");
        chk({5'h00, valid_three[2:0]}, 8'h07, "three: add not held");
        step(1);
        chk({5'h00, stage_valid_o[4:2]}, 8'h04, "mul in commit, add still held");
        chk({5'h00, valid_eight[4:2]}, 8'h04, "eight: mul past first access");
        chk({6'h00, prefetch_level_o}, 8'h02, "buffer filled in stall");
        step(1);
        chk({7'h00, stage_valid_o[2]}, 8'h01, "add leaves after two");
        dec(CAT_ALU, 5'h01, 5'h02);
        fetch_ready_i = 1'b0;
        step(1);
        chk({6'h00, prefetch_level_o}, 8'h01, "fetch fed from buffer");
        chk({7'h00, stage_valid_o[0]}, 8'h01, "fetch full from buffer");
        step(1);
        chk({6'h00, prefetch_level_o}, 8'h00, "buffer drained");
        step(1);
        chk({7'h00, stage_valid_o[0]}, 8'h00, "fetch empty when drained");
        fetch_ready_i = 1'b1;
        step(5);
        $display("mul hazard done");
    endtask
    // load to slow memory holds, barrier behind it empties the buffer
    task automatic test_slow_load();
        dec(CAT_LOAD, 5'h09, 5'h0A);
        step(1);
        dec(CAT_BARRIER, 5'h00, 5'h00);
        data_done_i = 1'b0;
        step(1);
        dec(CAT_ALU, 5'h0A, 5'h0B);
        step(4);
        chk({6'h00, stage_valid_o[4:3]}, 8'h01, "load held, bubble after");
        chk({7'h00, hold_o}, 8'h01, "slow access stall");
        chk({6'h00, prefetch_level_o}, 8'h02, "buffer full in stall");
        data_done_i = 1'b1;
        step(2);
        chk({6'h00, prefetch_level_o}, 8'h00, "barrier empties buffer");
        dec(CAT_ALU, 5'h01, 5'h02);
        step(4);
        $display("slow load done");
    endtask
    // divide stalls execute while a dependent add waits on it too
    task automatic test_div_overlap();
        dec(CAT_DIV, 5'h0C, 5'h0D);
        exec_done_i = 1'b0;
        step(1);
        dec(CAT_ALU, 5'h0E, 5'h0C);
        step(2);
        chk({6'h00, stage_valid_o[3:2]}, 8'h01, "divide held in execute");
        chk({7'h00, hold_o}, 8'h01, "divide stall");
        exec_done_i = 1'b1;
        step(1);
        chk({6'h00, stage_valid_o[3:2]}, 8'h02, "divide moved on");
        step(1);
        chk({7'h00, stage_valid_o[2]}, 8'h01, "longest stall only");
        dec(CAT_ALU, 5'h01, 5'h02);
        step(4);
        $display("divide overlap done");
    endtask
    // taken branch flushes the front and refills in two
    task automatic test_branch();
        dec(CAT_BRANCH, 5'h00, 5'h02);
        step(1);
        dec(CAT_ALU, 5'h01, 5'h02);
        branch_taken_i = 1'b1;
        step(1);
        branch_taken_i = 1'b0;
        chk({5'h00, stage_valid_o[2:0]}, 8'h01, "front flushed, target fetched");
        chk({7'h00, flush_o}, 8'h01, "flush pulse");
        step(1);
        chk({7'h00, flush_o}, 8'h00, "flush one cycle");
        chk({7'h00, stage_valid_o[2]}, 8'h00, "second refill bubble");
        step(1);
        chk({7'h00, stage_valid_o[2]}, 8'h01, "target in execute");
        step(4);
        $display("branch done");
    endtask
    // eight stages hold a stream behind an excepting load; five stages do not
    task automatic test_stream();
        dec_excp_i = 1'b1;
        dec(CAT_LOAD, 5'h05, 5'h06);
        step(1);
        dec_excp_i = 1'b0;
        dec(CAT_STREAM, 5'h07, 5'h08);
        step(1);
        chk({7'h00, valid_eight[2]}, 8'h00, "eight: stream held");
        chk({7'h00, stage_valid_o[2]}, 8'h01, "five: stream flows");
        dec(CAT_ALU, 5'h01, 5'h02);
        step(8);
        $display("stream done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        step(6);
        reset_i = 1'b0;
        test_flow();
        test_mul_hazard();
        test_slow_load();
        test_div_overlap();
        test_branch();
        test_stream();
        print_verdict();
    end
endmodule
`default_nettype wire
